// >>> src/dcs_defines.svh
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
`define DCS_OFS_SOFT 8'h00
`define DCS_OFS_OTACT 8'h04
`define DCS_OFS_LINK 8'h08
`define DCS_OFS_MODE2 8'h0C
`define DCS_OFS_OTLVL 8'h10
`define DCS_OFS_OTTIME 8'h14
`define DCS_OFS_MFO 8'h18
`define DCS_OFS_MFI 8'h1C
`define DCS_OFS_STATUS 8'h20
`define DCS_OFS_OUTREF 8'h24
`define DCS_RST_OTLVL 16'h00A0
`define DCS_RST_OTTIME_MS 16'h0064
`define DCS_OT_HYST_PCT 16'h000A
`define DCS_CLK_MHZ 100
`define DCS_TICK_US 1000
`define DCS_TICK_CYC (`DCS_CLK_MHZ * `DCS_TICK_US)
`define DCS_SCAN_MS 2
`define DCS_HOLD_MS 400
`define DCS_SC_02_MS 16'h00C8
`define DCS_SC_05_MS 16'h01F4
`define DCS_SC_10_MS 16'h03E8
`define DCS_OT_CODE 4'hB
`define DCS_LR_CODE 4'h1
`endif

// >>> src/dcs_pkg.sv
package dcs_pkg;
    typedef enum logic [1:0] {
        DCS_SRC_LINK = 2'b00,
        DCS_SRC_TERM = 2'b01,
        DCS_SRC_KEY = 2'b10
    } dcs_src_type;
    typedef enum logic [1:0] {
        DCS_STOP_RAMP1 = 2'b00,
        DCS_STOP_COAST = 2'b01,
        DCS_STOP_RAMP2 = 2'b10,
        DCS_STOP_CONT = 2'b11
    } dcs_stop_type;
    typedef enum logic [1:0] {
        DCS_HOLD_IDLE = 2'b00,
        DCS_HOLD_ACT = 2'b01
    } dcs_hold_type;
    typedef struct packed {
        logic forward_run;
        logic reverse_run;
        logic [9:0] ref_pct;
    } dcs_cmd_type;
endpackage

// >>> src/dcs_supervisor.sv
`timescale 1ns/100ps
`include "dcs_defines.svh"
module dcs_supervisor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [7:0] TERMINAL_IN,
    input wire logic [9:0] TERMINAL_REF,
    input wire logic KEY_RUN,
    input wire logic KEY_STOP,
    input wire logic KEY_FWD_REV,
    input wire logic KEY_DUAL,
    input wire logic [9:0] KEY_REF,
    input wire dcs_pkg::dcs_cmd_type LINK_CMD,
    input wire logic LINK_ERROR,
    input wire logic [15:0] OUTPUT_CURRENT,
    input wire logic [9:0] OUTPUT_FREQ,
    input wire logic FREQ_AGREE,
    input wire logic DC_BRAKING,
    input wire logic RUNNING,
    output logic RUN_FWD,
    output logic RUN_REV,
    output logic JOG,
    output logic [9:0] FREQ_REF,
    output logic [15:0] SCURVE_MS,
    output logic SCURVE_DECEL_END,
    output logic STOP_COAST,
    output logic STOP_DECEL_TWO,
    output logic STOP_REQ,
    output logic OUTPUT_SHUTOFF,
    output logic FAULT_CONTACT,
    output logic OVERTORQUE_INDICATION,
    output logic OVERTORQUE_BLINK,
    output logic [2:0] MF_OUT,
    output logic LOCAL_MODE
);
    // Register file
    logic [3:0] soft_start_reference_select_r;
    logic [3:0] overtorque_action_select_r;
    logic [3:0] serial_link_source_select_r;
    logic [3:0] operation_mode_select_two_r;
    logic [15:0] overtorque_level_r;
    logic [15:0] overtorque_time_r;
    logic [11:0] multifunction_output_setting_r;
    logic [15:0] multifunction_input_setting_r;

    // Digit fields, first digit in bit 0; the stop code reads third digit first
    wire rev_prohibit = operation_mode_select_two_r[1];
    wire scan_once = operation_mode_select_two_r[2];
    wire key_lr = operation_mode_select_two_r[3];
    wire [1:0] scurve_code = soft_start_reference_select_r[1:0];
    wire ref_inverse = soft_start_reference_select_r[2];
    wire hold_en = soft_start_reference_select_r[3];
    wire ot_en = overtorque_action_select_r[0];
    wire ot_anytime = overtorque_action_select_r[1];
    wire ot_trip = overtorque_action_select_r[2];
    wire ref_local_src = serial_link_source_select_r[0];
    wire cmd_local_src = serial_link_source_select_r[1];
    wire [1:0] err_sel = {serial_link_source_select_r[2], serial_link_source_select_r[3]};

    // AXI4-Lite slave: write taken once both channels have arrived
    logic aw_got_r, w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire do_write = aw_got_r && w_got_r && !S_AXI_BVALID;
    assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got_r && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire [7:0] rd_addr = S_AXI_ARADDR[7:0];

    function automatic logic [31:0] put_lanes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= `DCS_OFS_OUTREF;
    endfunction

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR[7:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= mapped(aw_addr_r) ? 2'b00 : 2'b10;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register writes; status and output words are read only
    wire [31:0] wv = put_lanes(32'h0000_0000, w_data_r, w_strb_r);
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            soft_start_reference_select_r <= 4'h0;
            overtorque_action_select_r <= 4'h0;
            serial_link_source_select_r <= 4'h3;
            operation_mode_select_two_r <= 4'h0;
            overtorque_level_r <= `DCS_RST_OTLVL;
            overtorque_time_r <= `DCS_RST_OTTIME_MS;
            multifunction_output_setting_r <= 12'h000;
            multifunction_input_setting_r <= 16'h0000;
        end else if (do_write) begin
            case (aw_addr_r)
                `DCS_OFS_SOFT: soft_start_reference_select_r <= wv[3:0];
                `DCS_OFS_OTACT: overtorque_action_select_r <= wv[3:0];
                `DCS_OFS_LINK: serial_link_source_select_r <= wv[3:0];
                `DCS_OFS_MODE2: operation_mode_select_two_r <= wv[3:0];
                `DCS_OFS_OTLVL: overtorque_level_r <= wv[15:0];
                `DCS_OFS_OTTIME: overtorque_time_r <= wv[15:0];
                `DCS_OFS_MFO: multifunction_output_setting_r <= wv[11:0];
                `DCS_OFS_MFI: multifunction_input_setting_r <= wv[15:0];
                default: ;
            endcase
        end
    end

    // Terminal, key and link error pins pass two flops before use; the reference inputs do not
    logic [7:0] term_s1_r, term_s2_r;
    logic [4:0] key_s1_r, key_s2_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            term_s1_r <= 8'h00;
            term_s2_r <= 8'h00;
            key_s1_r <= 5'h00;
            key_s2_r <= 5'h00;
        end else begin
            term_s1_r <= TERMINAL_IN;
            term_s2_r <= term_s1_r;
            key_s1_r <= {KEY_RUN, KEY_STOP, KEY_FWD_REV, KEY_DUAL, LINK_ERROR};
            key_s2_r <= key_s1_r;
        end
    end
    wire k_run = key_s2_r[4];
    wire k_stop = key_s2_r[3];
    wire k_dir = key_s2_r[2];
    wire k_dual = key_s2_r[1];
    wire link_err = key_s2_r[0];

    // Scan tick; twin sampling filters contact bounce
    localparam int SCAN_CYC = `DCS_TICK_CYC * `DCS_SCAN_MS;
    logic [31:0] scan_cnt_r;
    logic [7:0] samp_r, term_r;
    wire scan_tick = scan_cnt_r == 32'(SCAN_CYC - 1);
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            scan_cnt_r <= 32'h0000_0000;
            samp_r <= 8'h00;
            term_r <= 8'h00;
        end else begin
            scan_cnt_r <= scan_tick ? 32'h0000_0000 : scan_cnt_r + 32'h0000_0001;
            if (scan_tick) begin
                samp_r <= term_s2_r;
                if (scan_once) term_r <= term_s2_r;
                else if (samp_r == term_s2_r) term_r <= term_s2_r;
            end
        end
    end

    // Local/remote selection
    logic local_r, dual_d_r, dir_d_r;
    wire dual_press = k_dual && !dual_d_r;
    wire [3:0] mfi_code [4];
    genvar g;
    wire [3:0] lr_hit;
    generate
        for (g = 0; g < 4; g++) begin : g_mfi
            assign mfi_code[g] = multifunction_input_setting_r[g*4 +: 4];
            assign lr_hit[g] = mfi_code[g] == `DCS_LR_CODE && term_r[4+g];
        end
    endgenerate
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            local_r <= 1'b0;
            dual_d_r <= 1'b0;
            dir_d_r <= 1'b0;
        end else begin
            dual_d_r <= k_dual;
            dir_d_r <= k_dir;
            if (key_lr && dual_press && !RUNNING) local_r <= !local_r;
        end
    end
    wire eff_local = local_r || |lr_hit;
    assign LOCAL_MODE = eff_local;
    assign JOG = !key_lr && k_dual && local_r;

    // Source selection
    logic key_fwd_dir_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) key_fwd_dir_r <= 1'b1;
        else if (k_dir && !dir_d_r && !RUNNING) key_fwd_dir_r <= !key_fwd_dir_r;
    end
    wire key_fwd = k_run && key_fwd_dir_r;
    wire key_rev = k_run && !key_fwd_dir_r;
    wire [9:0] term_ref = ref_inverse ? 10'h3FF - TERMINAL_REF : TERMINAL_REF;
    wire [9:0] local_ref = eff_local ? KEY_REF : term_ref;
    wire [9:0] sel_ref = ref_local_src ? local_ref : LINK_CMD.ref_pct;
    wire sel_fwd = cmd_local_src ? (eff_local ? key_fwd : term_r[0]) : LINK_CMD.forward_run;
    wire sel_rev = cmd_local_src ? (eff_local ? key_rev : term_r[1]) : LINK_CMD.reverse_run;

    // Reference loss hold
    localparam int HOLD_CYC = `DCS_TICK_CYC * `DCS_HOLD_MS;
    logic [31:0] hold_cnt_r;
    logic [9:0] ref_prev_r, hold_ref_r;
    dcs_pkg::dcs_hold_type hold_st_r;
    wire hold_tick = hold_cnt_r == 32'(HOLD_CYC - 1);
    wire [19:0] prev_x10 = 20'(ref_prev_r) * 20'd10;
    wire [19:0] cur_x100 = 20'(sel_ref) * 20'd100;
    wire ref_lost = cur_x100 < prev_x10;
    wire [9:0] eighty = 10'((20'(ref_prev_r) * 20'd80) / 20'd100);
    wire low_freq = 20'(OUTPUT_FREQ) * 20'd100 < 20'd5 * 20'h003FF;
    wire stop_cmd = !(sel_fwd || sel_rev);
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_cnt_r <= 32'h0000_0000;
            ref_prev_r <= 10'h000;
            hold_ref_r <= 10'h000;
            hold_st_r <= dcs_pkg::DCS_HOLD_IDLE;
        end else begin
            hold_cnt_r <= hold_tick ? 32'h0000_0000 : hold_cnt_r + 32'h0000_0001;
            case (hold_st_r)
                dcs_pkg::DCS_HOLD_IDLE: begin
                    if (hold_tick) begin
                        if (hold_en && ref_lost && !low_freq && !stop_cmd) begin
                            hold_st_r <= dcs_pkg::DCS_HOLD_ACT;
                            hold_ref_r <= eighty;
                        end else begin
                            ref_prev_r <= sel_ref;
                        end
                    end
                end
                dcs_pkg::DCS_HOLD_ACT: begin
                    if (!hold_en || stop_cmd || sel_ref > hold_ref_r) begin
                        hold_st_r <= dcs_pkg::DCS_HOLD_IDLE;
                        ref_prev_r <= sel_ref;
                    end
                end
                default: hold_st_r <= dcs_pkg::DCS_HOLD_IDLE;
            endcase
        end
    end
    wire holding = hold_st_r == dcs_pkg::DCS_HOLD_ACT;

    // Overtorque timer at 1 ms resolution with release hysteresis
    logic [31:0] ms_cnt_r;
    logic [15:0] ot_ms_r;
    logic ot_r, ot_latch_r;
    wire ms_tick = ms_cnt_r == 32'(`DCS_TICK_CYC - 1);
    wire ot_window = ot_anytime ? !DC_BRAKING : FREQ_AGREE;
    wire [16:0] rel_lvl = 17'(overtorque_level_r) - 17'(`DCS_OT_HYST_PCT);
    wire over_lvl = OUTPUT_CURRENT >= overtorque_level_r;
    wire under_rel = 17'(OUTPUT_CURRENT) < rel_lvl || rel_lvl[16];
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ms_cnt_r <= 32'h0000_0000;
            ot_ms_r <= 16'h0000;
            ot_r <= 1'b0;
            ot_latch_r <= 1'b0;
        end else begin
            ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
            if (!ot_en || !ot_window) begin
                ot_ms_r <= 16'h0000;
                ot_r <= 1'b0;
            end else if (!over_lvl) begin
                ot_ms_r <= 16'h0000;
                if (under_rel) ot_r <= 1'b0;
            end else if (ms_tick) begin
                if (ot_ms_r >= overtorque_time_r) ot_r <= 1'b1;
                else ot_ms_r <= ot_ms_r + 16'h0001;
            end
            if (ot_r && ot_trip) ot_latch_r <= 1'b1;
            else if (!RUNNING && !ot_r && k_stop) ot_latch_r <= 1'b0;
        end
    end

    // Multi-function outputs
    generate
        for (g = 0; g < 3; g++) begin : g_mfo
            assign MF_OUT[g] = ot_r && multifunction_output_setting_r[g*4 +: 4] == `DCS_OT_CODE;
        end
    endgenerate
    assign OVERTORQUE_INDICATION = ot_r || ot_latch_r;
    assign OVERTORQUE_BLINK = ot_r && !ot_trip;
    assign OUTPUT_SHUTOFF = ot_latch_r;
    assign FAULT_CONTACT = ot_latch_r;

    // Link error stop method; continue mode waits for the keypad stop key
    dcs_pkg::dcs_stop_type stop_sel;
    assign stop_sel = dcs_pkg::dcs_stop_type'(err_sel);
    wire link_used = !cmd_local_src || !ref_local_src;
    wire err_act = link_err && link_used;
    assign STOP_COAST = err_act && stop_sel == dcs_pkg::DCS_STOP_COAST;
    assign STOP_DECEL_TWO = err_act && stop_sel == dcs_pkg::DCS_STOP_RAMP2;
    wire err_stop = err_act && (stop_sel != dcs_pkg::DCS_STOP_CONT || k_stop);
    assign STOP_REQ = err_stop || (eff_local && k_stop);

    // Run and reference outputs
    logic fwd_r, rev_r;
    logic [9:0] ref_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fwd_r <= 1'b0;
            rev_r <= 1'b0;
            ref_r <= 10'h000;
        end else begin
            fwd_r <= sel_fwd && !STOP_REQ && !ot_latch_r;
            rev_r <= sel_rev && !rev_prohibit && !STOP_REQ && !ot_latch_r;
            ref_r <= holding ? hold_ref_r : sel_ref;
        end
    end
    assign RUN_FWD = fwd_r;
    assign RUN_REV = rev_r;
    assign FREQ_REF = ref_r;

    // S-curve choice; code 00 drops the shaping at end of deceleration
    assign SCURVE_MS = scurve_code == 2'b00 ? `DCS_SC_02_MS :
                       scurve_code == 2'b10 ? `DCS_SC_05_MS :
                       scurve_code == 2'b11 ? `DCS_SC_10_MS : 16'h0000;
    assign SCURVE_DECEL_END = scurve_code != 2'b00 && scurve_code != 2'b01;

    // Status and read path
    wire [31:0] status = {27'h0, holding, ot_latch_r, ot_r, eff_local, local_r};
    wire [31:0] rd_mux =
        rd_addr == `DCS_OFS_SOFT ? {28'h0, soft_start_reference_select_r} :
        rd_addr == `DCS_OFS_OTACT ? {28'h0, overtorque_action_select_r} :
        rd_addr == `DCS_OFS_LINK ? {28'h0, serial_link_source_select_r} :
        rd_addr == `DCS_OFS_MODE2 ? {28'h0, operation_mode_select_two_r} :
        rd_addr == `DCS_OFS_OTLVL ? {16'h0, overtorque_level_r} :
        rd_addr == `DCS_OFS_OTTIME ? {16'h0, overtorque_time_r} :
        rd_addr == `DCS_OFS_MFO ? {20'h0, multifunction_output_setting_r} :
        rd_addr == `DCS_OFS_MFI ? {16'h0, multifunction_input_setting_r} :
        rd_addr == `DCS_OFS_STATUS ? status :
        rd_addr == `DCS_OFS_OUTREF ? {22'h0, ref_r} : 32'h0000_0000;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b00;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= mapped(rd_addr) ? 2'b00 : 2'b10;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule // dcs_supervisor

// >>> verif/dcs_far_model.sv
`timescale 1ns/100ps
module dcs_far_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic [9:0] freq_ref,
    input wire logic [15:0] load_pct,
    output logic running,
    output logic [9:0] output_freq,
    output logic freq_agree,
    output logic dc_braking,
    output logic [15:0] output_current
);
    logic [2:0] brake_cnt_r;
    // Power stage lags the run outputs a cycle; short braking tail after a stop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            running <= 1'b0;
            output_freq <= 10'h000;
            brake_cnt_r <= 3'h0;
        end else begin
            running <= run_fwd | run_rev;
            output_freq <= running ? freq_ref : 10'h000;
            if (running && !(run_fwd | run_rev)) begin
                brake_cnt_r <= 3'h4;
            end else if (brake_cnt_r != 3'h0) begin
                brake_cnt_r <= brake_cnt_r - 3'h1;
            end
        end
    end
    // Current only flows while the motor turns
    assign dc_braking = brake_cnt_r != 3'h0;
    assign freq_agree = running && output_freq == freq_ref;
    assign output_current = running ? load_pct : 16'h0000;
endmodule // dcs_far_model

// >>> verif/dcs_supervisor_props.sv
`timescale 1ns/100ps
module dcs_supervisor_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [15:0] SCURVE_MS,
    input wire logic SCURVE_DECEL_END,
    input wire logic STOP_COAST,
    input wire logic STOP_DECEL_TWO,
    input wire logic OUTPUT_SHUTOFF,
    input wire logic FAULT_CONTACT,
    input wire logic OVERTORQUE_INDICATION,
    input wire logic OVERTORQUE_BLINK,
    input wire logic [2:0] MF_OUT
);
    // One domain, so clock and reset are given once
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Bus steps used by the handshake checks
    sequence s_both_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    chk_write_answer: assert property (s_both_taken |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
    chk_read_answer: assert property (s_ar_taken |=> S_AXI_RVALID)
        else $error("read data late");
    chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    chk_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while answer pending");
    chk_scurve_off: assert property (SCURVE_MS == 16'h0000 |-> !SCURVE_DECEL_END)
        else $error("decel shaping without s-curve");
    chk_decel_end_code: assert property (SCURVE_DECEL_END |->
        SCURVE_MS == 16'h01F4 || SCURVE_MS == 16'h03E8) else $error("decel shaping at 0.2 s");
    chk_stop_single: assert property (STOP_COAST |-> !STOP_DECEL_TWO)
        else $error("two stop methods at once");
    chk_trip_fault: assert property ($rose(OUTPUT_SHUTOFF) |-> FAULT_CONTACT)
        else $error("trip without fault contact");
    chk_blink_runs: assert property (OVERTORQUE_BLINK |-> !OUTPUT_SHUTOFF)
        else $error("blink mode shut output off");
    chk_mf_overtorque: assert property (MF_OUT != 3'h0 |->
        OVERTORQUE_INDICATION || OVERTORQUE_BLINK) else $error("mf output without overtorque");
endmodule // dcs_supervisor_props

bind dcs_supervisor dcs_supervisor_props u_dcs_supervisor_props (.CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .SCURVE_MS(SCURVE_MS), .SCURVE_DECEL_END(SCURVE_DECEL_END), .STOP_COAST(STOP_COAST),
    .STOP_DECEL_TWO(STOP_DECEL_TWO), .OUTPUT_SHUTOFF(OUTPUT_SHUTOFF),
    .FAULT_CONTACT(FAULT_CONTACT), .OVERTORQUE_INDICATION(OVERTORQUE_INDICATION),
    .OVERTORQUE_BLINK(OVERTORQUE_BLINK), .MF_OUT(MF_OUT));

// >>> verif/testbench.sv
`timescale 1ns/100ps
`define TB_CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic arvalid = 1'b0, rready = 1'b1, link_err = 1'b0;
    logic [31:0] awaddr = 32'h00000000, wdata = 32'h00000000, araddr = 32'h00000000, rdata;
    logic [3:0] keys = 4'h0; // Run, stop, direction, dual key
    logic [9:0] term_ref = 10'h000, key_ref = 10'h000, freq_ref, out_freq;
    dcs_pkg::dcs_cmd_type link_cmd = '0;
    logic awready, wready, bvalid, arready, rvalid, run_fwd, run_rev, jog, decel_end;
    logic stop_coast, stop_two, stop_req, running, agree, braking, local_mode;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] scurve_ms, current;
    int n_errors = 0;
    int tests_run = 0;
    dcs_supervisor u_dcs_supervisor (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .TERMINAL_IN(8'h00), .TERMINAL_REF(term_ref), .KEY_RUN(keys[3]), .KEY_STOP(keys[2]),
        .KEY_FWD_REV(keys[1]), .KEY_DUAL(keys[0]), .KEY_REF(key_ref), .LINK_CMD(link_cmd),
        .LINK_ERROR(link_err), .OUTPUT_CURRENT(current), .OUTPUT_FREQ(out_freq),
        .FREQ_AGREE(agree), .DC_BRAKING(braking), .RUNNING(running), .RUN_FWD(run_fwd),
        .RUN_REV(run_rev), .JOG(jog), .FREQ_REF(freq_ref), .SCURVE_MS(scurve_ms),
        .SCURVE_DECEL_END(decel_end), .STOP_COAST(stop_coast), .STOP_DECEL_TWO(stop_two),
        .STOP_REQ(stop_req), .OUTPUT_SHUTOFF(), .FAULT_CONTACT(), .OVERTORQUE_INDICATION(),
        .OVERTORQUE_BLINK(), .MF_OUT(), .LOCAL_MODE(local_mode));
    dcs_far_model u_dcs_far_model (.clk(clk), .rst_n(rst_n), .run_fwd(run_fwd),
        .run_rev(run_rev), .freq_ref(freq_ref), .load_pct(16'h0032), .running(running),
        .output_freq(out_freq), .freq_agree(agree), .dc_braking(braking),
        .output_current(current));
    // Clock and watchdog; the whole run needs well under 20k cycles
    initial forever #5 clk = ~clk;
    initial begin
        #300000;
        n_errors++;
        report_and_stop();
    end
    // Answers read at the falling edge; bready and rready stay high
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            resp = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end while (!b_hit);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_hit, r_hit;
        logic [31:0] d;
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
        end while (!r_hit);
        `TB_CHECK(d, e)
        `TB_CHECK(resp, er)
    endtask
    // Keys go to a new level, held past the synchroniser
    task automatic press(input logic [3:0] m);
        keys <= m;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_regs();
        rd_chk(8'h08, 32'h00000003, 2'h0);
        rd_chk(8'h04, 32'h00000000, 2'h0);
        rd_chk(8'h10, 32'h000000A0, 2'h0);
        rd_chk(8'h14, 32'h00000064, 2'h0);
        wr(8'h0C, 32'h00000005);
        rd_chk(8'h0C, 32'h00000005, 2'h0);
        wr(8'h40, 32'h00000001);
        `TB_CHECK(resp, 2'h2)
        rd_chk(8'h40, 32'h00000000, 2'h2);
    endtask
    task automatic t_scurve();
        logic [15:0] ms [4] = '{16'h00C8, 16'h0000, 16'h01F4, 16'h03E8};
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'(c));
            repeat (2) @(posedge clk);
            `TB_CHECK(scurve_ms, ms[c])
            `TB_CHECK(decel_end, 1'(c >= 2))
        end
    endtask
    // Option card drives; continue mode first, the others stop the drive
    task automatic t_link();
        logic [1:0] c;
        wr(8'h08, 32'h00000000);
        link_cmd <= '{forward_run: 1'b1, reverse_run: 1'b0, ref_pct: 10'h12C};
        repeat (4) @(posedge clk);
        `TB_CHECK(run_fwd, 1'b1)
        `TB_CHECK(freq_ref, 10'h12C)
        for (int k = 0; k < 4; k++) begin
            c = 2'(3 + k);
            wr(8'h08, {28'h0000000, c, 2'h0});
            link_err <= 1'b1;
            repeat (5) @(posedge clk);
            `TB_CHECK(stop_coast, c == 2'h2)
            `TB_CHECK(stop_two, c == 2'h1)
            `TB_CHECK(stop_req, c != 2'h3)
            if (c == 2'h3) `TB_CHECK(run_fwd, 1'b1)
            link_err <= 1'b0;
            repeat (5) @(posedge clk);
        end
        link_cmd <= '0;
        wr(8'h08, 32'h00000003);
        repeat (10) @(posedge clk);
    endtask
    task automatic t_local();
        wr(8'h0C, 32'h00000008);
        press(4'h1);
        press(4'h0);
        `TB_CHECK(local_mode, 1'b1)
        key_ref <= 10'h1F4;
        press(4'h8);
        `TB_CHECK(run_fwd, 1'b1)
        `TB_CHECK(freq_ref, 10'h1F4)
        press(4'h9);
        press(4'h8);
        `TB_CHECK(local_mode, 1'b1)
        press(4'hC);
        `TB_CHECK(run_fwd, 1'b0)
        press(4'h0);
        wr(8'h0C, 32'h0000000A);
        press(4'h2);
        press(4'hA);
        `TB_CHECK(run_rev, 1'b0)
        wr(8'h0C, 32'h00000008);
        press(4'h8);
        `TB_CHECK(run_rev, 1'b1)
        press(4'h0);
        wr(8'h0C, 32'h00000000);
        press(4'h1);
        `TB_CHECK(jog, 1'b1)
        `TB_CHECK(local_mode, 1'b1)
        press(4'h0);
        wr(8'h0C, 32'h00000008);
        press(4'h1);
        press(4'h0);
        `TB_CHECK(local_mode, 1'b0)
    endtask
    // Remote, terminal reference, straight then inverted
    task automatic t_inverse();
        term_ref <= 10'h064;
        repeat (5) @(posedge clk);
        `TB_CHECK(freq_ref, 10'h064)
        wr(8'h00, 32'h00000004);
        repeat (5) @(posedge clk);
        `TB_CHECK(freq_ref, 10'h39B)
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_scurve();
        t_link();
        t_local();
        t_inverse();
        report_and_stop();
    end
endmodule // testbench
